// ==== rtl/sleep_ctrl_pkg.sv ====
// Package for the sleep and system control register block.
// Shared by the device end, the core end and the window timer.
package sleep_ctrl_pkg;
  // Data-space offsets and the short I/O bias
  localparam logic [7:0] SLEEP_MODE_CONTROL_OFS = 8'h53;
  localparam logic [7:0] SYSTEM_CONTROL_OFS     = 8'h55;
  localparam logic [7:0] IO_SPACE_BIAS          = 8'h20;
  localparam logic [7:0] EXT_IO_START           = 8'h60;
  // Reset values
  localparam logic [7:0] SLEEP_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] SYSTEM_CONTROL_RST     = 8'h00;
  // Field positions, sleep mode control
  localparam int SLEEP_ENABLE_POS = 0;
  localparam int SLEEP_MODE_LSB   = 1;
  // Field positions, system control
  localparam int DEBUG_DIS_POS  = 7;
  localparam int BOD_DIS_POS    = 6;
  localparam int BOD_DIS_EN_POS = 5;
  localparam int PULLUP_DIS_POS = 4;
  localparam int VEC_SEL_POS    = 1;
  localparam int VEC_CHG_EN_POS = 0;
  // Writable bit masks; other bits read zero
  localparam logic [7:0] SLEEP_MODE_CONTROL_MASK = 8'h0F;
  localparam logic [7:0] SYSTEM_CONTROL_MASK     = 8'hF3;
  // Timed windows, in system clock cycles
  localparam logic [2:0] WINDOW_CYCLES   = 3'h4;
  localparam logic [2:0] BOD_DELAY_CYCLES = 3'h3;
  localparam logic [2:0] BOD_HOLD_CYCLES  = 3'h3;
  // Brown-out settle time after wake, microseconds, and cycles at 50 MHz
  localparam int BOD_WAKE_US     = 60;
  localparam int CLK_MHZ         = 50;
  localparam int BOD_WAKE_CYCLES = BOD_WAKE_US * CLK_MHZ;
  // Sleep mode encodings
  typedef enum logic [2:0] {
    MODE_IDLE     = 3'h0,
    MODE_NOISE    = 3'h1,
    MODE_PWR_DOWN = 3'h2,
    MODE_PWR_SAVE = 3'h3,
    MODE_RSV4     = 3'h4,
    MODE_RSV5     = 3'h5,
    MODE_STANDBY  = 3'h6,
    MODE_EXT_STBY = 3'h7
  } sleep_mode_t;
endpackage : sleep_ctrl_pkg

// ==== rtl/sleep_ctrl_if.sv ====
// Interface joining the core end and the device end.
// Carries register accesses (data space and short I/O) and the sleep op.
`timescale 1ns/10ps
`default_nettype none
interface sleep_ctrl_if;
  logic       wrEn;      // One-cycle write strobe
  logic       rdEn;      // One-cycle read strobe
  logic       ioSpace;   // Address is a short I/O address
  logic [7:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;    // Valid the cycle after rdEn
  logic       sleepOp;   // One-cycle sleep instruction
  logic       asleep;    // Device is in sleep or in the wake settle
  logic       wake;      // One-cycle wake request to device
  logic       intBlock;  // Interrupts held off

  modport device (
    input  wrEn, rdEn, ioSpace, addr, wrData, sleepOp, wake,
    output rdData, asleep, intBlock
  );
  modport core (
    output wrEn, rdEn, ioSpace, addr, wrData, sleepOp, wake,
    input  rdData, asleep, intBlock
  );
endinterface : sleep_ctrl_if
`default_nettype wire

// ==== rtl/timed_window.sv ====
// Small down-counter opened by a pulse, closed by expiry or a close pulse.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module timed_window
  import sleep_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       open,
  input  wire logic       close,
  input  wire logic [2:0] length,
  // Status
  output logic            active
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // Open wins over close so a re-arm in the closing cycle is kept
  always_comb begin
    cnt_d = cnt_q;
    if (open) begin
      cnt_d = length;
    end else if (close) begin
      cnt_d = 3'h0;
    end else if (cnt_q != 3'h0) begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign active = (cnt_q != 3'h0);
endmodule : timed_window
`default_nettype wire

// ==== rtl/sleep_ctrl_device.sv ====
// Device end: sleep mode control and system control registers, timed
// write sequences, sleep entry and the power gating outputs that follow.
// Assumes the core issues one access per strobe on the same clock.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module sleep_ctrl_device
  import sleep_ctrl_pkg::*;
#(
  parameter int WAKE_SETTLE = BOD_WAKE_CYCLES
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Core side
  sleep_ctrl_if.device bus,
  // Fuses and lock straps, static
  input  wire logic   debugPortFuse,
  input  wire logic   debugSystemFuse,
  input  wire logic   brownoutLevelFuses,
  input  wire logic   applicationBootLock,
  input  wire logic   bootSideLock,
  input  wire logic   runningInBoot,
  input  wire logic   converterEnabled,
  input  wire logic   watchdogEnabled,
  // Pin request from port logic
  input  wire logic   pinDirectionBit,
  input  wire logic   pinOutputBit,
  // Power and system outputs
  output logic        debugPortEnable,
  output logic        pullupEnable,
  output logic        vectorSelect,
  output logic        mainClockOn,
  output logic        ioClockOn,
  output logic        converterOn,
  output logic        comparatorOn,
  output logic        inputBuffersOn,
  output logic        brownoutOn,
  output logic        watchdogOn
);
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_SETTLE} pwr_state_t;

  logic [7:0]  smc_q, smc_d, sysc_q, sysc_d, rd_q, rd_d;
  logic        jtdVal_q, jtdVal_d;
  logic        bodDis_q, bodDis_d, bodOffSleep_q, bodOffSleep_d;
  logic        intBlk_d, ivselWritten_q, ivselWritten_d;
  pwr_state_t  st_q, st_d;
  logic [2:0]  bodCnt_q, bodCnt_d;
  logic [12:0] settle_q, settle_d;
  logic [7:0]  dataAddr;
  logic        hitSmc, hitSys, jtdWin, bodWin, ivWin, bodActive;
  logic        ivceOpen, bodseOpen, jtdOpen, ivselWrite;

  // Short I/O addresses below the extended space get the bias added
  assign dataAddr = bus.ioSpace ? bus.addr + IO_SPACE_BIAS : bus.addr;
  assign hitSmc = (dataAddr == SLEEP_MODE_CONTROL_OFS)
                  && !(bus.ioSpace && bus.addr >= 8'h40);
  assign hitSys = (dataAddr == SYSTEM_CONTROL_OFS)
                  && !(bus.ioSpace && bus.addr >= 8'h40);

  assign ivceOpen  = bus.wrEn && hitSys && bus.wrData[VEC_CHG_EN_POS];
  assign ivselWrite = bus.wrEn && hitSys && ivWin
                      && !bus.wrData[VEC_CHG_EN_POS];
  assign bodseOpen = bus.wrEn && hitSys && bus.wrData[BOD_DIS_EN_POS]
                     && bus.wrData[BOD_DIS_POS];
  assign jtdOpen   = bus.wrEn && hitSys && !jtdWin
                     && (bus.wrData[DEBUG_DIS_POS] != sysc_q[DEBUG_DIS_POS]);

  // Sequence windows; each opens on its enabling write
  timed_window ivWinU (.clk(clk), .rst_n(rst_n), .open(ivceOpen),
    .close(ivselWrite), .length(WINDOW_CYCLES), .active(ivWin));
  timed_window bodWinU (.clk(clk), .rst_n(rst_n), .open(bodseOpen),
    .close(1'b0), .length(WINDOW_CYCLES), .active(bodWin));
  timed_window jtdWinU (.clk(clk), .rst_n(rst_n), .open(jtdOpen),
    .close(1'b0), .length(WINDOW_CYCLES), .active(jtdWin));

  // Active only once the delay part of the count has run out
  assign bodActive = bodDis_q && (bodCnt_q <= BOD_HOLD_CYCLES);

  // Register writes, timed sequences and read data
  always_comb begin
    smc_d = smc_q;
    sysc_d = sysc_q;
    jtdVal_d = jtdVal_q;
    bodDis_d = bodDis_q;
    bodCnt_d = bodCnt_q;
    ivselWritten_d = 1'b0;
    rd_d = 8'h00;
    // Change enable only stands while its window is open
    if (!ivWin) begin
      sysc_d[VEC_CHG_EN_POS] = 1'b0;
    end
    if (!bodWin) begin
      sysc_d[BOD_DIS_EN_POS] = 1'b0;
    end
    // Brown-out disable: delay then hold, then self-clear
    if (bodDis_q) begin
      bodCnt_d = bodCnt_q - 3'h1;
      if (bodCnt_q == 3'h1) begin
        bodDis_d = 1'b0;
        sysc_d[BOD_DIS_POS] = 1'b0;
      end
    end
    if (bus.wrEn && hitSmc) begin
      smc_d = bus.wrData & SLEEP_MODE_CONTROL_MASK;
    end
    if (bus.wrEn && hitSys) begin
      sysc_d[PULLUP_DIS_POS] = bus.wrData[PULLUP_DIS_POS];
      // Debug disable: second equal write inside the window commits
      if (jtdWin && bus.wrData[DEBUG_DIS_POS] == jtdVal_q) begin
        sysc_d[DEBUG_DIS_POS] = jtdVal_q;
      end
      jtdVal_d = bus.wrData[DEBUG_DIS_POS];
      if (bus.wrData[BOD_DIS_EN_POS] && bus.wrData[BOD_DIS_POS]) begin
        sysc_d[BOD_DIS_EN_POS] = 1'b1;
      end else if (bodWin && bus.wrData[BOD_DIS_POS]) begin
        sysc_d[BOD_DIS_EN_POS] = 1'b0;
        sysc_d[BOD_DIS_POS] = 1'b1;
        bodDis_d = 1'b1;
        bodCnt_d = BOD_DELAY_CYCLES + BOD_HOLD_CYCLES;
      end
      if (ivselWrite) begin
        sysc_d[VEC_SEL_POS] = bus.wrData[VEC_SEL_POS];
        sysc_d[VEC_CHG_EN_POS] = 1'b0;
        ivselWritten_d = 1'b1;
      end else if (ivceOpen) begin
        sysc_d[VEC_CHG_EN_POS] = 1'b1;
      end
    end
    // Block lasts through the instruction after the vector write
    intBlk_d = ivceOpen || ivWin || ivselWritten_q;
    if (bus.rdEn) begin
      if (hitSmc) begin
        rd_d = smc_q & SLEEP_MODE_CONTROL_MASK;
      end else if (hitSys) begin
        rd_d = sysc_q & SYSTEM_CONTROL_MASK;
      end
    end
  end

  // Sleep entry, brown-out latch and wake settle
  always_comb begin
    st_d = st_q;
    bodOffSleep_d = bodOffSleep_q;
    settle_d = settle_q;
    unique case (st_q)
      ST_RUN: begin
        if (bus.sleepOp && smc_q[SLEEP_ENABLE_POS]) begin
          st_d = ST_SLEEP;
          bodOffSleep_d = bodActive;
        end
      end
      ST_SLEEP: begin
        if (bus.wake) begin
          bodOffSleep_d = 1'b0;
          if (bodOffSleep_q) begin
            st_d = ST_SETTLE;
            settle_d = 13'(WAKE_SETTLE);
          end else begin
            st_d = ST_RUN;
          end
        end
      end
      ST_SETTLE: begin
        if (settle_q <= 13'h1) begin
          st_d = ST_RUN;
        end else begin
          settle_d = settle_q - 13'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smc_q <= SLEEP_MODE_CONTROL_RST;
      sysc_q <= SYSTEM_CONTROL_RST;
      rd_q <= 8'h00;
      jtdVal_q <= 1'b0;
      bodDis_q <= 1'b0;
      bodCnt_q <= 3'h0;
      ivselWritten_q <= 1'b0;
      st_q <= ST_RUN;
      bodOffSleep_q <= 1'b0;
      settle_q <= 13'h0;
    end else begin
      smc_q <= smc_d;
      sysc_q <= sysc_d;
      rd_q <= rd_d;
      jtdVal_q <= jtdVal_d;
      bodDis_q <= bodDis_d;
      bodCnt_q <= bodCnt_d;
      ivselWritten_q <= ivselWritten_d;
      st_q <= st_d;
      bodOffSleep_q <= bodOffSleep_d;
      settle_q <= settle_d;
    end
  end

  // Power gating decoded from mode and state, registered once more
  logic [9:0] pwr_q, pwr_d;
  logic       sl, deep, ioStop, blk;
  sleep_mode_t mode;
  always_comb begin
    mode = sleep_mode_t'(smc_q[SLEEP_MODE_LSB +: 3]);
    sl = (st_q == ST_SLEEP);
    deep = sl && (mode != MODE_IDLE) && (mode != MODE_NOISE);
    ioStop = sl && (mode != MODE_IDLE);
    // Section locks hold interrupts off in the other section
    // Next value used so the block starts with the enabling write
    blk = intBlk_d
          || (sysc_q[VEC_SEL_POS] && applicationBootLock && !runningInBoot)
          || (!sysc_q[VEC_SEL_POS] && bootSideLock && runningInBoot);
    pwr_d[0] = debugPortFuse && !sysc_q[DEBUG_DIS_POS];
    pwr_d[1] = !sysc_q[PULLUP_DIS_POS]
               && !pinDirectionBit && pinOutputBit;
    pwr_d[2] = sysc_q[VEC_SEL_POS];
    pwr_d[3] = !deep || (debugSystemFuse
               && !sysc_q[DEBUG_DIS_POS]);
    pwr_d[4] = !ioStop;
    pwr_d[5] = converterEnabled;
    pwr_d[6] = !deep;
    // Deep modes stop both the comparator and the input buffers
    pwr_d[7] = !deep;
    pwr_d[8] = brownoutLevelFuses && !bodOffSleep_q;
    pwr_d[9] = blk;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_q <= 10'h0;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign debugPortEnable = pwr_q[0];
  assign pullupEnable    = pwr_q[1];
  assign vectorSelect    = pwr_q[2];
  assign mainClockOn     = pwr_q[3];
  assign ioClockOn       = pwr_q[4];
  assign converterOn     = pwr_q[5];
  assign comparatorOn    = pwr_q[6];
  assign inputBuffersOn  = pwr_q[7];
  assign brownoutOn      = pwr_q[8];
  assign watchdogOn      = watchdogEnabled;
  assign bus.rdData      = rd_q;
  assign bus.asleep      = (st_q != ST_RUN);
  assign bus.intBlock    = pwr_q[9];
endmodule : sleep_ctrl_device
`default_nettype wire

// ==== rtl/sleep_ctrl_core.sv ====
// Core end: Avalon-MM slave with orders, runs the timed sequences on
// the link. Assumes the device end is on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sleep_ctrl_core
  import sleep_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link to device
  sleep_ctrl_if.core       bus
);
  // Word 0: raw access {wk[28],sl[27],wr[26],rd[25],io[24],addr[23:16],data[7:0]}
  localparam logic [3:0] CMD_OFS  = 4'h0;
  localparam logic [3:0] SEQ_OFS  = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  typedef enum logic [2:0] {S_IDLE, S_SECOND, S_WAIT, S_READ, S_DONE} cst_t;
  cst_t       st_q, st_d;
  logic       wr_q, wr_d, rd_q, rd_d, io_q, io_d, sl_q, sl_d, wk_q, wk_d;
  logic [7:0] ad_q, ad_d, wd_q, wd_d, wd2_q, wd2_d, last_q, last_d;
  logic [31:0] rdat_q, rdat_d;
  logic       wait_q, wait_d;

  // Accept, issue up to two strokes (none for reads), then release waitrequest
  always_comb begin
    st_d = st_q;
    wr_d = 1'b0; rd_d = 1'b0; sl_d = 1'b0; wk_d = 1'b0;
    io_d = io_q; ad_d = ad_q; wd_d = wd_q; wd2_d = wd2_q;
    last_d = last_q; rdat_d = rdat_q; wait_d = 1'b1;
    unique case (st_q)
      S_IDLE: begin
        if (avs_write) begin
          io_d = avs_writedata[24];
          ad_d = avs_writedata[23:16];
          wd_d = avs_writedata[7:0];
          wd2_d = avs_writedata[15:8];
          // Two-stroke sequence writes back to back, within four cycles
          if (avs_address == SEQ_OFS) begin
            wr_d = 1'b1; st_d = S_SECOND;
          end else if (avs_address == CMD_OFS) begin
            wr_d = avs_writedata[26];
            rd_d = avs_writedata[25];
            sl_d = avs_writedata[27];
            wk_d = avs_writedata[28];
            st_d = S_WAIT;
          end else begin
            st_d = S_DONE;
          end
        end else if (avs_read) begin
          rdat_d = (avs_address == STAT_OFS)
            ? {22'h0, bus.intBlock, bus.asleep, last_q} : 32'h0;
          st_d = S_DONE;
        end
      end
      S_SECOND: begin
        wr_d = 1'b1; wd_d = wd2_q; st_d = S_WAIT;
      end
      // Device read data stands one cycle after the read strobe
      S_WAIT: begin
        st_d = rd_q ? S_READ : S_DONE;
      end
      S_READ: begin
        last_d = bus.rdData; st_d = S_DONE;
      end
      S_DONE: begin
        wait_d = 1'b1; st_d = S_IDLE;
      end
    endcase
    if (st_d == S_DONE) begin
      wait_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE; wr_q <= 1'b0; rd_q <= 1'b0; io_q <= 1'b0;
      sl_q <= 1'b0; wk_q <= 1'b0; ad_q <= 8'h00; wd_q <= 8'h00;
      wd2_q <= 8'h00; last_q <= 8'h00; rdat_q <= 32'h0; wait_q <= 1'b1;
    end else begin
      st_q <= st_d; wr_q <= wr_d; rd_q <= rd_d; io_q <= io_d;
      sl_q <= sl_d; wk_q <= wk_d; ad_q <= ad_d; wd_q <= wd_d;
      wd2_q <= wd2_d; last_q <= last_d; rdat_q <= rdat_d;
      wait_q <= wait_d;
    end
  end

  assign bus.wrEn = wr_q;
  assign bus.rdEn = rd_q;
  assign bus.ioSpace = io_q;
  assign bus.addr = ad_q;
  assign bus.wrData = wd_q;
  assign bus.sleepOp = sl_q;
  assign bus.wake = wk_q;
  assign avs_readdata = rdat_q;
  assign avs_waitrequest = wait_q;
endmodule : sleep_ctrl_core
`default_nettype wire

// ==== verif/sleep_ctrl_chk.sv ====
// Checker on the link between the core end and the device end.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sleep_ctrl_chk
  import sleep_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link signals
  input wire logic       wrEn,
  input wire logic       rdEn,
  input wire logic       ioSpace,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic       sleepOp,
  input wire logic       asleep,
  input wire logic       wake,
  input wire logic       intBlock
);
  logic       modeHit;
  logic       sysHit;
  logic [3:0] modeShadow_q, modeShadow_d;
  logic [3:0] since_q, since_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Short I/O form sits IO_SPACE_BIAS below the data-space offset
  assign modeHit = addr == (ioSpace ? SLEEP_MODE_CONTROL_OFS - IO_SPACE_BIAS
                                    : SLEEP_MODE_CONTROL_OFS);
  assign sysHit  = addr == (ioSpace ? SYSTEM_CONTROL_OFS - IO_SPACE_BIAS
                                    : SYSTEM_CONTROL_OFS);

  // Shadow of the sleep register; age of the last system write, saturating
  always_comb begin
    modeShadow_d = modeShadow_q;
    since_d      = (since_q == 4'hF) ? since_q : since_q + 4'h1;
    if (wrEn && modeHit) modeShadow_d = wrData[3:0];
    if (wrEn && sysHit) since_d = 4'h0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeShadow_q <= 4'h0;
      since_q      <= 4'hF;
    end else begin
      modeShadow_q <= modeShadow_d;
      since_q      <= since_d;
    end
  end

  a_sleep_blocked: assert property (
    sleepOp && !modeShadow_q[0] && !asleep |=> !asleep)
    else $error("sleep entered with enable clear");
  a_sleep_taken: assert property (
    sleepOp && modeShadow_q[0] |-> ##[1:2] asleep)
    else $error("sleep not entered");
  a_asleep_cause: assert property (
    $rose(asleep) |-> $past(sleepOp) || $past(sleepOp, 2))
    else $error("sleep without sleep op");
  a_mode_readback: assert property (
    rdEn && modeHit |=> rdData == {4'h0, modeShadow_q})
    else $error("sleep register readback wrong");
  a_sys_reserved: assert property (
    rdEn && sysHit |=> rdData[3:2] == 2'h0)
    else $error("undefined system bits not zero");
  a_auto_clear: assert property (
    rdEn && sysHit && since_q == 4'hF |=> !rdData[6] && !rdData[0])
    else $error("self-clearing bit still set");
  a_block_start: assert property (
    wrEn && sysHit && wrData[VEC_CHG_EN_POS] |=> intBlock)
    else $error("interrupts not blocked");
  a_block_bound: assert property (
    $rose(intBlock) |-> ##[1:8] !intBlock)
    else $error("interrupt block too long");
  a_wake_ends: assert property (
    asleep && wake |-> ##[1:12] !asleep)
    else $error("no wake after request");

  // Main scenarios reached
  c_sleep: cover property (sleepOp && modeShadow_q[0]);
  c_block: cover property ($rose(intBlock));
  c_wake:  cover property (asleep && wake);
endmodule : sleep_ctrl_chk
`default_nettype wire

// ==== verif/test_sleep_and_system_control.sv ====
// Bench joining the core end and device end over the link interface.
// Drives the core's Avalon slave and the device's static straps.
`timescale 1ns/10ps
`default_nettype none
module test_sleep_and_system_control
  import sleep_ctrl_pkg::*;
;
  localparam logic [4:0] OP_IO = 5'h01, OP_RD = 5'h02, OP_WR = 5'h04;
  localparam logic [4:0] OP_SLP = 5'h08, OP_WK = 5'h10;
  localparam logic [3:0] CMD = 4'h0, SEQ = 4'h4, STAT = 4'h8;
  localparam logic [7:0] MA = SLEEP_MODE_CONTROL_OFS;
  localparam logic [7:0] SA = SYSTEM_CONTROL_OFS;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avAddr = 4'h0;
  logic        avRd = 1'b0;
  logic        avWr = 1'b0;
  logic [31:0] avWdata = 32'h0;
  logic [31:0] avRdata;
  logic        avWait;
  logic        dbgFuse = 1'b1, dbgSysFuse = 1'b0, bodFuses = 1'b1;
  logic        convEn = 1'b0, wdogEn = 1'b0, pinDir = 1'b0, pinOut = 1'b1;
  logic        dbgEn, puEn, vecSel, mainClk, ioClk;
  logic        convOn, cmpOn, bufOn, bodOn, wdogOn;
  int          num_errors = 0;
  int          cmp_count = 0;

  // 50 MHz system clock
  always #10 clk = ~clk;

  sleep_ctrl_if u_sleep_ctrl_if ();
  sleep_ctrl_core u_sleep_ctrl_core (.clk(clk), .rst_n(rst_n),
    .avs_address(avAddr), .avs_read(avRd), .avs_write(avWr),
    .avs_writedata(avWdata), .avs_readdata(avRdata),
    .avs_waitrequest(avWait), .bus(u_sleep_ctrl_if));
  // Short settle count keeps the wake path quick in simulation
  sleep_ctrl_device #(.WAKE_SETTLE(5)) u_sleep_ctrl_device (.clk(clk),
    .rst_n(rst_n), .bus(u_sleep_ctrl_if), .debugPortFuse(dbgFuse),
    .debugSystemFuse(dbgSysFuse), .brownoutLevelFuses(bodFuses),
    .applicationBootLock(1'b0), .bootSideLock(1'b0), .runningInBoot(1'b0),
    .converterEnabled(convEn), .watchdogEnabled(wdogEn),
    .pinDirectionBit(pinDir), .pinOutputBit(pinOut),
    .debugPortEnable(dbgEn), .pullupEnable(puEn), .vectorSelect(vecSel),
    .mainClockOn(mainClk), .ioClockOn(ioClk), .converterOn(convOn),
    .comparatorOn(cmpOn), .inputBuffersOn(bufOn), .brownoutOn(bodOn),
    .watchdogOn(wdogOn));
  sleep_ctrl_chk u_sleep_ctrl_chk (.clk(clk), .rst_n(rst_n),
    .wrEn(u_sleep_ctrl_if.wrEn), .rdEn(u_sleep_ctrl_if.rdEn),
    .ioSpace(u_sleep_ctrl_if.ioSpace), .addr(u_sleep_ctrl_if.addr),
    .wrData(u_sleep_ctrl_if.wrData), .rdData(u_sleep_ctrl_if.rdData),
    .sleepOp(u_sleep_ctrl_if.sleepOp), .asleep(u_sleep_ctrl_if.asleep),
    .wake(u_sleep_ctrl_if.wake), .intBlock(u_sleep_ctrl_if.intBlock));

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic chk1(input string nm, input logic e, g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  // One Avalon access, held until waitrequest is sampled low
  task automatic av(input logic [3:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avAddr  <= a;
    avWr    <= w;
    avRd    <= !w;
    avWdata <= d;
    @(posedge clk);
    while (avWait !== 1'b0 && n < 64) begin
      @(posedge clk);
      n++;
    end
    q = avRdata;
    if (n >= 64) chk("waitrequest", 32'h0, 32'h1);
    avRd <= 1'b0;
    avWr <= 1'b0;
    @(posedge clk);
  endtask : av

  // Link order through the command or sequence slot
  task automatic op(input logic [3:0] s, input logic [4:0] k,
                    input logic [7:0] a, d, input logic [7:0] d2 = 8'h00);
    logic [31:0] q;
    av(s, 1'b1, {3'h0, k, a, d2, d}, q);
  endtask : op

  task automatic stat(output logic [31:0] q);
    av(STAT, 1'b0, 32'h0, q);
  endtask : stat

  task automatic rchk(input string nm, input logic [7:0] a, input logic io,
                      input logic [7:0] e);
    logic [31:0] q;
    op(CMD, OP_RD | {4'h0, io}, a, 8'h00);
    stat(q);
    chk(nm, {24'h0, e}, {24'h0, q[7:0]});
  endtask : rchk

  task automatic t_regs;
    logic [31:0] q;
    rchk("mode reset", MA, 1'b0, 8'h00);
    rchk("sys reset", SA, 1'b0, 8'h00);
    op(CMD, OP_WR, MA, 8'hFF);
    rchk("mode mask", MA, 1'b0, 8'h0F);
    rchk("mode short io", MA - IO_SPACE_BIAS, 1'b1, 8'h0F);
    op(CMD, OP_WR | OP_IO, MA, 8'h00);
    rchk("ext not via io", MA, 1'b0, 8'h0F);
    op(CMD, OP_WR | OP_IO, MA - IO_SPACE_BIAS, 8'h02);
    rchk("mode io write", MA, 1'b0, 8'h02);
    op(CMD, OP_WR, SA, 8'h1C);
    rchk("sys mask", SA, 1'b0, 8'h10);
    chk1("pullup off", 1'b0, puEn);
    op(CMD, OP_WR, SA, 8'h00);
    chk1("pullup on", 1'b1, puEn);
    pinDir <= 1'b1;
    repeat (2) @(posedge clk);
    chk1("pullup output", 1'b0, puEn);
    av(4'hC, 1'b0, 32'h0, q);
    chk("unmapped read", 32'h0, q);
  endtask : t_regs

  task automatic t_sleep;
    logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [31:0] q;
    foreach (modes[i]) begin
      convEn     <= i[0];
      wdogEn     <= i[1];
      dbgSysFuse <= i[2];
      op(CMD, OP_WR, MA, {4'h0, modes[i], 1'b0});
      op(CMD, OP_SLP, 8'h00, 8'h00);
      stat(q);
      chk1("no sleep", 1'b0, q[8]);
      op(CMD, OP_WR, MA, {4'h0, modes[i], 1'b1});
      op(CMD, OP_SLP, 8'h00, 8'h00);
      stat(q);
      chk1("asleep", 1'b1, q[8]);
      chk1("io clock", modes[i] == 3'h0, ioClk);
      chk1("converter", convEn, convOn);
      chk1("watchdog", wdogEn, wdogOn);
      chk1("detector", 1'b1, bodOn);
      if (modes[i] >= 3'h2) chk1("comparator", 1'b0, cmpOn);
      if (modes[i] >= 3'h2) chk1("buffers", 1'b0, bufOn);
      if (dbgSysFuse) chk1("main clock", 1'b1, mainClk);
      op(CMD, OP_WK, 8'h00, 8'h00);
      repeat (12) @(posedge clk);
      stat(q);
      chk1("woken", 1'b0, q[8]);
      op(CMD, OP_WR, MA, 8'h00);
    end
  endtask : t_sleep

  task automatic t_debug;
    chk1("debug reset", 1'b1, dbgEn);
    op(CMD, OP_WR, SA, 8'h80);
    rchk("debug one write", SA, 1'b0, 8'h00);
    op(SEQ, OP_WR, SA, 8'h80, 8'h80);
    rchk("debug twice", SA, 1'b0, 8'h80);
    chk1("debug off", 1'b0, dbgEn);
    dbgFuse <= 1'b0;
    op(SEQ, OP_WR, SA, 8'h00, 8'h00);
    chk1("debug fuse", 1'b0, dbgEn);
    dbgFuse <= 1'b1;
    repeat (2) @(posedge clk);
    chk1("debug on", 1'b1, dbgEn);
  endtask : t_debug

  task automatic t_vector;
    logic [31:0] q;
    op(CMD, OP_WR, SA, 8'h02);
    chk1("vector plain", 1'b0, vecSel);
    op(SEQ, OP_WR, SA, 8'h01, 8'h02);
    chk1("vector boot", 1'b1, vecSel);
    rchk("change enable clear", SA, 1'b0, 8'h02);
    op(SEQ, OP_WR, SA, 8'h01, 8'h00);
    chk1("vector flash", 1'b0, vecSel);
    op(CMD, OP_WR, SA, 8'h01);
    repeat (4) @(posedge clk);
    rchk("enable expired", SA, 1'b0, 8'h00);
    stat(q);
    chk1("block released", 1'b0, q[9]);
    op(CMD, OP_WR, MA, 8'h05);
    op(SEQ, OP_WR, SA, 8'h60, 8'h40);
    op(CMD, OP_SLP, 8'h00, 8'h00);
    chk1("detector off", 1'b0, bodOn);
    op(CMD, OP_WK, 8'h00, 8'h00);
    stat(q);
    chk1("settling", 1'b1, q[8]);
    repeat (8) @(posedge clk);
    chk1("detector back", 1'b1, bodOn);
    rchk("detector bit cleared", SA, 1'b0, 8'h00);
  endtask : t_vector

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_sleep;
    t_debug;
    t_vector;
    report_and_stop;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
endmodule : test_sleep_and_system_control
`default_nettype wire
